// >>> core/sysrst_pkg.sv
// Summary of operation
// RL1 - reset starts from the external pin, software reset or watchdog overflow
// RL2 - on reset, cancel hold states and let the internal access cycle finish
// RL3 - hardware and software reset abort the bus cycle, then tristate bus and IO
// RL4 - the internal sequence always lasts exactly 516 CPU clock cycles
// RL5 - hold reset for the full sequence, then while the reset pin stays low
// RL6 - at reset end latch straps and drive ALE, RD and WR inactive
// RL7 - after reset, fetch starts at address zero in code segment zero
// RL8 - the outside holds the reset pin low at least 2 clocks for warm reset
// RL9 - the outside holds the pin low 1036 clocks for power-on reset
// RL10 - the software reset instruction starts the sequence at any time
// RL11 - soft and watchdog resets ignore strap bits 5 to 0
// RL12 - watchdog reset completes or aborts the bus cycle depending on ready
// RL13 - no watchdog reset in bootstrap loader mode
// RL14 - bus enabled after the sequence, general IO stays high-impedance input
// RL15 - a prolonged reset delays enabling the outputs until it ends
// RL16 - system reset output goes low at every start, high at end of init
// RL17 - system reset output follows the pin asynchronously, else clocked
// RL18 - watchdog restarts at clock by 2 with reload 00h, overflow after 131072
// RL19 - watchdog flag set by watchdog reset, cleared by hardware reset or service
// RL20 - watchdog disable honoured only before the first service or end of init
// RL21 - special registers cleared except pointers, stack limits and watchdog control
// RL22 - internal RAM is never touched by any reset
package sysrst_pkg;

	// sequence timing
	localparam int unsigned SEQ_CYCLES     = 516;
	localparam int unsigned SEQ_CNT_W      = 10;
	localparam int unsigned POR_PIN_CYCLES = 1036;

	// watchdog
	localparam int unsigned WDT_W          = 16;
	localparam int unsigned PRESC_W        = 7;
	localparam logic [PRESC_W-1:0] PRESC_DIV2   = 7'h01;
	localparam logic [PRESC_W-1:0] PRESC_DIV128 = 7'h7F;
	localparam logic [WDT_W-1:0]   WDT_MAX      = 16'hFFFF;
	localparam logic [7:0]         WDT_RELOAD_RST = 8'h00;

	// watchdog control field positions
	localparam int unsigned WATCHDOG_CONTROL_REG_IN_BIT  = 0;
	localparam int unsigned WATCHDOG_CONTROL_REG_FLAG_BIT = 1;
	localparam int unsigned WATCHDOG_CONTROL_REG_REL_LSB = 8;

	// register reset values
	localparam logic [15:0] DATA_PAGE_POINTER_1_RST       = 16'h0001;
	localparam logic [15:0] DATA_PAGE_POINTER_2_RST       = 16'h0002;
	localparam logic [15:0] DATA_PAGE_POINTER_3_RST       = 16'h0003;
	localparam logic [15:0] CP_RST         = 16'hFC00;
	localparam logic [15:0] SP_RST         = 16'hFC00;
	localparam logic [15:0] STACK_UNDERFLOW_LIMIT_RST      = 16'hFC00;
	localparam logic [15:0] STACK_OVERFLOW_LIMIT_RST      = 16'hFA00;
	localparam logic [15:0] WATCHDOG_CONTROL_REG_WDT_RST = 16'h0002;
	localparam logic [15:0] WATCHDOG_CONTROL_REG_RST     = 16'h0000;

	// start of execution
	localparam logic [23:0] RESET_VECTOR   = 24'h000000;

	// strap bits honoured only on hardware reset
	localparam logic [15:0] STRAP_HW_MASK  = 16'h003F;

	// register map, byte addresses
	localparam logic [7:0] ADDR_WATCHDOG_CONTROL_REG     = 8'h00;
	localparam logic [7:0] ADDR_WDTCNT     = 8'h04;
	localparam logic [7:0] ADDR_STATUS     = 8'h08;

	// reset source codes in status
	typedef enum logic [1:0] {
		SRC_NONE,
		SRC_HW,
		SRC_SW,
		SRC_WDT
	} rst_src_e;

	// preset values handed to the special registers
	typedef struct packed {
		logic [15:0] data_page_pointer_1;
		logic [15:0] data_page_pointer_2;
		logic [15:0] data_page_pointer_3;
		logic [15:0] context_pointer;
		logic [15:0] stack_pointer;
		logic [15:0] stack_underflow_limit;
		logic [15:0] stack_overflow_limit;
		logic [15:0] watchdog_control_reg;
	} sfr_init_s;

	// pin state commands to the port logic
	typedef struct packed {
		logic bus_hiz;
		logic gpio_hiz;
		logic strobes_idle;
		logic bus_enable;
	} pin_ctrl_s;

endpackage

// >>> core/system_reset_sequencer.sv
`timescale 1ns/1ps
module system_reset_sequencer
	import sysrst_pkg::*;
(
	// clock and power reset
	input  wire logic              core_clk_in,
	input  wire logic              reset_n_in,
	// reset pin and straps
	input  wire logic              ext_reset_request_in,
	input  wire logic [15:0]       config_strap_port_in,
	// cpu instruction pulses and the bootstrap mode level
	input  wire logic              software_reset_instr_in,
	input  wire logic              end_init_instr_in,
	input  wire logic              watchdog_service_instr_in,
	input  wire logic              watchdog_disable_instr_in,
	input  wire logic              bootstrap_mode_in,
	input  wire logic              gpio_reprogram_in,
	// bus state
	input  wire logic              internal_access_busy_in,
	input  wire logic              ext_cycle_active_in,
	input  wire logic              ext_cycle_uses_ready_in,
	input  wire logic              ext_ready_high_in,
	// ahb-lite slave
	input  wire logic              hsel_in,
	input  wire logic [31:0]       haddr_in,
	input  wire logic [1:0]        htrans_in,
	input  wire logic              hwrite_in,
	input  wire logic [2:0]        hsize_in,
	input  wire logic [31:0]       hwdata_in,
	input  wire logic              hready_in,
	output logic                   hreadyout_out,
	output logic                   hresp_out,
	output logic [31:0]            hrdata_out,
	// reset outputs
	output logic                   system_reset_out,
	output logic                   core_reset_out,
	output logic                   hold_cancel_out,
	output logic                   bus_abort_out,
	output pin_ctrl_s              pin_ctrl_out,
	output logic                   fetch_start_out,
	output logic [23:0]            fetch_addr_out,
	output logic [15:0]            strap_latched_out,
	output sfr_init_s              sfr_init_out,
	output logic                   watchdog_reset_flag_out
);

	typedef enum logic [1:0] {
		ST_RUN,
		ST_DRAIN,
		ST_SEQ,
		ST_EXTEND
	} seq_state_e;

	seq_state_e           state_q;
	rst_src_e             src_q;
	logic                 ext_sync1_q;
	logic                 ext_sync2_q;
	logic [15:0]          strap_sync1_q;
	logic [15:0]          strap_sync2_q;
	logic [SEQ_CNT_W-1:0] seq_cnt_q;
	logic [WDT_W-1:0]     wdt_cnt_q;
	logic [PRESC_W-1:0]   presc_q;
	logic                 wdt_en_q;
	logic                 dis_allowed_q;
	logic [7:0]           wdt_reload_q;
	logic                 wdt_in_q;
	logic                 wdt_flag_q;
	logic                 sysrst_q;
	logic                 ahb_wr_q;
	logic [7:0]           ahb_addr_q;

	wire logic rst_out_clr_n;
	wire logic ahb_go;
	wire logic wdt_tick;
	wire logic wdt_ovf;
	wire logic sw_req;
	wire logic hw_req;
	wire logic start_req;
	wire logic drain_done;
	wire logic seq_last;
	wire logic reset_end;
	wire logic service_ok;

	// event decode
	// the pin is only trusted after both synchroniser stages; a pulse shorter
	// than a clock may or may not start a reset, so the outside must hold
	// the pin low for at least two clocks
	assign hw_req     = ~ext_sync2_q;                            // RL1
	assign sw_req     = software_reset_instr_in;                 // RL10
	assign wdt_tick   = wdt_in_q ? (presc_q == PRESC_DIV128) : (presc_q[0] == PRESC_DIV2[0]);
	assign wdt_ovf    = wdt_en_q & wdt_tick & (wdt_cnt_q == WDT_MAX) & ~bootstrap_mode_in; // RL13
	assign start_req  = (state_q == ST_RUN) & (hw_req | sw_req | wdt_ovf); // RL1
	assign seq_last   = (seq_cnt_q == SEQ_CNT_W'(SEQ_CYCLES - 1));  // RL4
	assign reset_end  = ((state_q == ST_SEQ) & seq_last & ext_sync2_q) |
	                    ((state_q == ST_EXTEND) & ext_sync2_q);  // RL5
	assign service_ok = (state_q == ST_RUN) & watchdog_service_instr_in;
	// watchdog waits for a bus cycle that will finish, otherwise all wait on internal access
	assign drain_done = ~internal_access_busy_in &
	                    ~((src_q == SRC_WDT) & ext_cycle_active_in &
	                      ext_cycle_uses_ready_in & ~ext_ready_high_in); // RL2 RL12

	// pin synchronisers
	// straps pass the same two stages; they are only latched at reset end,
	// so a slow settle on those pins does no harm
	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			ext_sync1_q   <= 1'b0;
			ext_sync2_q   <= 1'b0;
			strap_sync1_q <= 16'h0000;
			strap_sync2_q <= 16'h0000;
		end else begin
			ext_sync1_q   <= ext_reset_request_in;
			ext_sync2_q   <= ext_sync1_q;
			strap_sync1_q <= config_strap_port_in;
			strap_sync2_q <= strap_sync1_q;
		end
	end

	// sequence state machine
	// power reset lands straight in the sequence as a hardware reset, and the
	// pin, still low through the synchronisers, decides any extension
	// the counter is cleared in run so every sequence starts from zero
	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state_q   <= ST_SEQ;
			src_q     <= SRC_HW;
			seq_cnt_q <= '0;
		end else begin
			unique case (state_q)
				ST_RUN: begin
					seq_cnt_q <= '0;
					if (start_req) begin
						state_q <= ST_DRAIN;
						if (hw_req)
							src_q <= SRC_HW;
						else if (sw_req)
							src_q <= SRC_SW;
						else
							src_q <= SRC_WDT;
					end
				end
				ST_DRAIN: begin
					if (drain_done)
						state_q <= ST_SEQ; // RL2
				end
				ST_SEQ: begin
					seq_cnt_q <= seq_cnt_q + SEQ_CNT_W'(1);
					if (seq_last)
						state_q <= ext_sync2_q ? ST_RUN : ST_EXTEND; // RL4 RL5
				end
				ST_EXTEND: begin
					if (ext_sync2_q)
						state_q <= ST_RUN; // RL5 RL15
				end
			endcase
		end
	end

	// internal reset condition and one-cycle reset actions
	// core reset rises the cycle after a request and falls the cycle after reset end
	// the abort pulse marks the one cycle in which a running bus cycle is cut
	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			core_reset_out  <= 1'b1;
			hold_cancel_out <= 1'b0;
			bus_abort_out   <= 1'b0;
			fetch_start_out <= 1'b0;
			fetch_addr_out  <= RESET_VECTOR;
		end else begin
			core_reset_out  <= (state_q != ST_RUN) ? ~reset_end : start_req;
			hold_cancel_out <= start_req;                             // RL2
			// watchdog aborts only when ready was seen high
			bus_abort_out   <= (state_q == ST_DRAIN) & drain_done & ext_cycle_active_in &
			                   ((src_q != SRC_WDT) | (ext_cycle_uses_ready_in &
			                    ext_ready_high_in));              // RL3 RL12
			fetch_start_out <= reset_end;                             // RL7
			fetch_addr_out  <= RESET_VECTOR;                          // RL7
		end
	end

	// pin driver control
	// drivers go quiet before the sequence so nothing fights the pins
	// general io stays an input after reset end until software reprograms it
	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			pin_ctrl_out <= '{bus_hiz: 1'b1, gpio_hiz: 1'b1, strobes_idle: 1'b0,
			                  bus_enable: 1'b0};
		end else if ((state_q == ST_DRAIN) & drain_done) begin
			pin_ctrl_out <= '{bus_hiz: 1'b1, gpio_hiz: 1'b1, strobes_idle: 1'b0,
			                  bus_enable: 1'b0};                      // RL3
		end else if (reset_end) begin
			pin_ctrl_out.bus_hiz      <= 1'b0;                        // RL14 RL15
			pin_ctrl_out.strobes_idle <= 1'b1;                        // RL6
			pin_ctrl_out.bus_enable   <= 1'b1;                        // RL14
		end else if ((state_q == ST_RUN) & gpio_reprogram_in) begin
			pin_ctrl_out.gpio_hiz     <= 1'b0;                        // RL14
		end
	end

	// strap capture at reset end, low bits only on hardware reset
	// soft and watchdog resets keep the previous low bits so a restart
	// cannot change modes that only a hardware reset may choose
	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			strap_latched_out <= 16'h0000;
		end else if (reset_end) begin
			if (src_q == SRC_HW)
				strap_latched_out <= strap_sync2_q;                       // RL6
			else
				strap_latched_out <= (strap_sync2_q & ~STRAP_HW_MASK) |
				                     (strap_latched_out & STRAP_HW_MASK); // RL11
		end
	end

	// presets for special registers; internal ram gets no clear at all
	// presets settle during the sequence, well before the core leaves reset
	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			sfr_init_out <= '{DATA_PAGE_POINTER_1_RST, DATA_PAGE_POINTER_2_RST, DATA_PAGE_POINTER_3_RST, CP_RST, SP_RST,
			                  STACK_UNDERFLOW_LIMIT_RST, STACK_OVERFLOW_LIMIT_RST, WATCHDOG_CONTROL_REG_RST};
		end else if (state_q == ST_SEQ) begin
			sfr_init_out <= '{DATA_PAGE_POINTER_1_RST, DATA_PAGE_POINTER_2_RST, DATA_PAGE_POINTER_3_RST, CP_RST, SP_RST, STACK_UNDERFLOW_LIMIT_RST,
			                  STACK_OVERFLOW_LIMIT_RST, (src_q == SRC_WDT) ? WATCHDOG_CONTROL_REG_WDT_RST :
			                  WATCHDOG_CONTROL_REG_RST};                            // RL21 RL22
		end
	end

	// system reset output: cleared at once by the pin, else clocked
	// the pin clears it without a clock so peripherals see the reset at once;
	// release needs an end of initialisation in run, so a pin held low
	// keeps it low whatever the sequencer does
	assign rst_out_clr_n = reset_n_in & ext_reset_request_in;
	always_ff @(posedge core_clk_in or negedge rst_out_clr_n) begin
		if (!rst_out_clr_n) begin
			sysrst_q <= 1'b0;                                         // RL17
		end else if (start_req) begin
			sysrst_q <= 1'b0;                                         // RL16 RL17
		end else if ((state_q == ST_RUN) & end_init_instr_in) begin
			sysrst_q <= 1'b1;                                         // RL16
		end
	end
	assign system_reset_out = sysrst_q;

	// watchdog counter and prescaler
	// both stay at zero through every reset, so the full default period
	// runs from reset end
	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			wdt_cnt_q <= '0;
			presc_q   <= '0;
		end else if (state_q != ST_RUN) begin
			wdt_cnt_q <= '0;                                          // RL18
			presc_q   <= '0;
		end else if (service_ok) begin
			wdt_cnt_q <= {wdt_reload_q, 8'h00};
			presc_q   <= '0;
		end else if (wdt_en_q) begin
			presc_q <= presc_q + PRESC_W'(1);
			if (wdt_tick)
				wdt_cnt_q <= wdt_cnt_q + WDT_W'(1);                       // RL18
		end
	end

	// watchdog enable and disable window
	// the disable window opens at reset end and closes at the first service
	// or end of initialisation, whichever comes first
	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			wdt_en_q      <= 1'b0;
			dis_allowed_q <= 1'b0;
		end else if (state_q != ST_RUN) begin
			wdt_en_q      <= reset_end;                               // RL18
			dis_allowed_q <= reset_end;                               // RL20
		end else begin
			if (dis_allowed_q & watchdog_disable_instr_in)
				wdt_en_q <= 1'b0;                                         // RL20
			if (watchdog_service_instr_in | end_init_instr_in)
				dis_allowed_q <= 1'b0;                                    // RL20
		end
	end

	// watchdog control register, flag set wins over service clear
	// writes land in the data phase; the sequence reloads the defaults and
	// overrides any write made while it runs
	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			wdt_reload_q <= WDT_RELOAD_RST;
			wdt_in_q     <= 1'b0;
			wdt_flag_q   <= 1'b0;
		end else if (state_q == ST_SEQ) begin
			wdt_reload_q <= WDT_RELOAD_RST;                           // RL18 RL21
			wdt_in_q     <= 1'b0;
			wdt_flag_q   <= (src_q == SRC_WDT);                       // RL19
		end else begin
			if (ahb_wr_q & (ahb_addr_q == ADDR_WATCHDOG_CONTROL_REG)) begin
				wdt_reload_q <= hwdata_in[WATCHDOG_CONTROL_REG_REL_LSB +: 8];
				wdt_in_q     <= hwdata_in[WATCHDOG_CONTROL_REG_IN_BIT];
			end
			if (wdt_ovf)
				wdt_flag_q <= 1'b1;
			else if (service_ok)
				wdt_flag_q <= 1'b0;                                       // RL19
		end
	end
	assign watchdog_reset_flag_out = wdt_flag_q;

	// ahb-lite address phase capture and read data, zero wait states
	// the write itself lands one cycle after the address phase
	// read data stands for the data phase only and falls back to zero
	assign ahb_go = hsel_in & hready_in & htrans_in[1];
	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			ahb_wr_q   <= 1'b0;
			ahb_addr_q <= 8'h00;
			hrdata_out <= 32'h00000000;
		end else begin
			ahb_wr_q   <= ahb_go & hwrite_in;
			ahb_addr_q <= haddr_in[7:0];
			hrdata_out <= 32'h00000000;
			if (ahb_go & ~hwrite_in) begin
				unique case (haddr_in[7:0])
					ADDR_WATCHDOG_CONTROL_REG: hrdata_out <= {16'h0000, wdt_reload_q, 6'h00, wdt_flag_q,
					                            wdt_in_q};
					ADDR_WDTCNT: hrdata_out <= {16'h0000, wdt_cnt_q};
					ADDR_STATUS: hrdata_out <= {12'h000, 1'b0, wdt_en_q, src_q,
					                            strap_latched_out};
					default:     hrdata_out <= 32'h00000000;
				endcase
			end
		end
	end

	// always ready, always okay
	// no wait states and no error response
	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			hreadyout_out <= 1'b1;
			hresp_out     <= 1'b0;
		end else begin
			hreadyout_out <= 1'b1;
			hresp_out     <= 1'b0;
		end
	end

endmodule

// >>> test/system_reset_sequencer_monitor.sv
`timescale 1ns/1ps
module system_reset_sequencer_monitor
	import sysrst_pkg::*;
(
	// clock and reset
	input  wire logic        core_clk_in,
	input  wire logic        reset_n_in,
	// observed inputs
	input  wire logic        ext_reset_request_in,
	input  wire logic        end_init_instr_in,
	// observed outputs
	input  wire logic        system_reset_out,
	input  wire logic        core_reset_out,
	input  wire logic        hold_cancel_out,
	input  wire logic        bus_abort_out,
	input  wire pin_ctrl_s   pin_ctrl_out,
	input  wire logic        fetch_start_out,
	input  wire logic [23:0] fetch_addr_out,
	input  wire logic        watchdog_reset_flag_out
);
	localparam int SEQ_MIN = SEQ_CYCLES;
	logic [11:0] high_q;
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!reset_n_in);
	// length of the current internal reset
	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in)
			high_q <= 12'h000;
		else
			high_q <= core_reset_out ? high_q + 12'h001 : 12'h000;
	end
	property p_seq_len; $fell(core_reset_out) |-> high_q >= SEQ_MIN; endproperty
	a_seq_len: assert property (p_seq_len) else $error("reset too short");
	property p_start; $rose(core_reset_out) |-> !system_reset_out && hold_cancel_out; endproperty
	a_start: assert property (p_start) else $error("reset start outputs");
	property p_release; $rose(system_reset_out) |-> $past(end_init_instr_in); endproperty
	a_release: assert property (p_release) else $error("reset output rose early");
	property p_pin_hold; !ext_reset_request_in [*4] |-> core_reset_out; endproperty
	a_pin_hold: assert property (p_pin_hold) else $error("pin low not honoured");
	property p_async; !ext_reset_request_in |-> !system_reset_out; endproperty
	a_async: assert property (p_async) else $error("reset output not following pin");
	property p_fetch;
		fetch_start_out |-> fetch_addr_out == 24'h000000 && !core_reset_out
			&& pin_ctrl_out.bus_enable && pin_ctrl_out.strobes_idle;
	endproperty
	a_fetch: assert property (p_fetch) else $error("bad state at fetch start");
	property p_hiz;
		$fell(core_reset_out) |-> $past(pin_ctrl_out.bus_hiz) && $past(pin_ctrl_out.gpio_hiz);
	endproperty
	a_hiz: assert property (p_hiz) else $error("pins driven in reset");
	property p_abort; bus_abort_out |-> core_reset_out; endproperty
	a_abort: assert property (p_abort) else $error("abort outside reset");
	property p_flag; $rose(watchdog_reset_flag_out) |-> core_reset_out; endproperty
	a_flag: assert property (p_flag) else $error("flag set outside reset");
endmodule
bind system_reset_sequencer system_reset_sequencer_monitor system_reset_sequencer_monitor_inst (
	.core_clk_in, .reset_n_in, .ext_reset_request_in, .end_init_instr_in, .system_reset_out,
	.core_reset_out, .hold_cancel_out, .bus_abort_out, .pin_ctrl_out, .fetch_start_out,
	.fetch_addr_out, .watchdog_reset_flag_out);

// >>> test/ext_reset_model.sv
`timescale 1ns/1ps
module ext_reset_model (
	// clock
	input  wire logic        core_clk_in,
	// hold request
	input  wire logic        start_in,
	input  wire logic [15:0] low_cycles_in,
	// reset pin, pulled up when released
	output logic             ext_reset_request_out
);
	logic [15:0] left_q = 16'h040C; // power-on hold of 1036 clocks
	// pin held low for the requested number of cycles
	always_ff @(posedge core_clk_in) begin
		if (start_in)
			left_q <= low_cycles_in;
		else if (left_q != 16'h0000)
			left_q <= left_q - 16'h0001;
	end
	assign ext_reset_request_out = (left_q == 16'h0000);
endmodule

// >>> test/system_reset_sequencer_tb.sv
`timescale 1ns/1ps
module system_reset_sequencer_tb import sysrst_pkg::*;;
	logic        core_clk_in, reset_n_in, boot, busy, xact, xuse, xhi, hwrite, ab, hc;
	logic        pin, hro, hresp, sysrst, crst, hco, abo, fst, wflag;
	logic [5:0]  pls;
	logic [15:0] strap, strl;
	logic [31:0] haddr, hwdata, hrd, rd;
	logic [1:0]  htrans;
	logic [23:0] faddr;
	pin_ctrl_s   pc;
	sfr_init_s   sfr;
	int          bad_count, cmp_count, n;
	// design under test
	system_reset_sequencer system_reset_sequencer_inst (.core_clk_in, .reset_n_in,
		.ext_reset_request_in(pin), .config_strap_port_in(strap),
		.software_reset_instr_in(pls[0]), .end_init_instr_in(pls[1]),
		.watchdog_service_instr_in(pls[2]), .watchdog_disable_instr_in(pls[3]),
		.bootstrap_mode_in(boot), .gpio_reprogram_in(pls[4]),
		.internal_access_busy_in(busy), .ext_cycle_active_in(xact),
		.ext_cycle_uses_ready_in(xuse), .ext_ready_high_in(xhi), .hsel_in(1'b1),
		.haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
		.hwdata_in(hwdata), .hready_in(hro), .hreadyout_out(hro), .hresp_out(hresp),
		.hrdata_out(hrd), .system_reset_out(sysrst), .core_reset_out(crst),
		.hold_cancel_out(hco), .bus_abort_out(abo), .pin_ctrl_out(pc),
		.fetch_start_out(fst), .fetch_addr_out(faddr), .strap_latched_out(strl),
		.sfr_init_out(sfr), .watchdog_reset_flag_out(wflag));
	// reset pin circuitry
	ext_reset_model ext_reset_model_inst (.core_clk_in, .start_in(pls[5]),
		.low_cycles_in(16'h0002), .ext_reset_request_out(pin));
	// clock
	initial begin
		core_clk_in = 1'b0;
		forever #12.5 core_clk_in = ~core_clk_in;
	end
	task automatic test_done();
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic check(input logic [127:0] seen, input logic [127:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// one-cycle strobe on the selected pulse inputs
	task automatic pulse(input logic [5:0] m);
		pls <= m;
		@(posedge core_clk_in);
		pls <= 6'h00;
	endtask
	// runs to fetch start, counting reset cycles
	task automatic wait_fetch();
		n = 0;
		ab = 1'b0;
		hc = 1'b0;
		for (int i = 0; i < 3000; i++) begin
			#1;
			if (crst === 1'b1) n++;
			if (abo === 1'b1) ab = 1'b1;
			if (hco === 1'b1) hc = 1'b1;
			if (fst === 1'b1) return;
			@(posedge core_clk_in);
		end
		bad_count++;
		test_done();
	endtask
	task automatic wait_rdy();
		for (int i = 0; i < 20; i++) begin
			@(posedge core_clk_in);
			if (hro === 1'b1) return;
		end
		bad_count++;
		test_done();
	endtask
	// single word transfer, address phase then data phase
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		haddr <= {24'h000000, a};
		hwrite <= wr;
		htrans <= 2'b10;
		wait_rdy();
		htrans <= 2'b00;
		hwdata <= wd;
		wait_rdy();
		rd = hrd;
	endtask
	function automatic logic [127:0] presets(input logic [15:0] w);
		return {DATA_PAGE_POINTER_1_RST, DATA_PAGE_POINTER_2_RST, DATA_PAGE_POINTER_3_RST, CP_RST, SP_RST, STACK_UNDERFLOW_LIMIT_RST, STACK_OVERFLOW_LIMIT_RST, w};
	endfunction
	// main sequence
	initial begin
		reset_n_in = 1'b0;
		{boot, busy, xact, xuse, xhi, hwrite, htrans, pls} = '0;
		haddr = 32'h00000000;
		hwdata = 32'h00000000;
		strap = 16'hA5C3;
		repeat (12) @(posedge core_clk_in);
		reset_n_in <= 1'b1;
		wait_fetch();
		check(n >= 1020, 1);
		check(sysrst, 0);
		check(sfr, presets(WATCHDOG_CONTROL_REG_RST));
		check(pc.gpio_hiz, 1);
		pulse(6'h10);
		#1 check(pc.gpio_hiz, 0);
		pulse(6'h02);
		#1 check(sysrst, 1);
		ahb(1'b0, ADDR_STATUS, 32'h0);
		check(rd, 32'h0005A5C3);
		ahb(1'b0, 8'h0C, 32'h0);
		check(rd, 32'h0);
		ahb(1'b1, ADDR_WATCHDOG_CONTROL_REG, 32'h0000FF00);
		ahb(1'b0, ADDR_WATCHDOG_CONTROL_REG, 32'h0);
		check(rd, 32'h0000FF00);
		$display("test power-on done");
		boot <= 1'b1;
		pulse(6'h04);
		@(posedge core_clk_in) pulse(6'h08);
		repeat (700) @(posedge core_clk_in);
		check(crst, 0);
		boot <= 1'b0;
		xact <= 1'b1;
		xuse <= 1'b1;
		xhi <= 1'b1;
		strap <= 16'h5A3C;
		pulse(6'h04);
		wait_fetch();
		check(n, SEQ_CYCLES + 1);
		check({ab, wflag, sysrst}, 3'b110);
		check(sfr, presets(WATCHDOG_CONTROL_REG_WDT_RST));
		ahb(1'b0, ADDR_STATUS, 32'h0);
		check(rd, 32'h00075A03);
		$display("test watchdog done");
		pulse(6'h02);
		@(posedge core_clk_in) pulse(6'h20);
		@(posedge core_clk_in) #1 check(sysrst, 0);
		wait_fetch();
		check({wflag, strl}, {1'b0, 16'h5A3C});
		$display("test warm reset done");
		pulse(6'h02);
		xuse <= 1'b0;
		strap <= 16'hFFFF;
		@(posedge core_clk_in) pulse(6'h01);
		wait_fetch();
		check(n, SEQ_CYCLES + 1);
		check({ab, hc, sysrst, strl}, {3'b110, 16'hFFFC});
		$display("test software reset done");
		test_done();
	end
endmodule
